// ---- rtl/hafc_top.sv ----
`timescale 1ns/1ps
module hafc_top (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Configuration capture
  input wire logic i_cfg_valid,
  input wire logic i_cfg_conv_en,
  input wire logic i_cfg_abs_mode,
  input wire logic [31:0] i_cfg_lw_pat,
  input wire logic [15:0] i_cfg_word_pat,
  input wire logic [15:0] i_cfg_bstr_pat,
  output logic o_cfg_done,
  output logic o_cfg_err,
  // Object request
  input wire logic i_req_valid,
  input wire hafc_pkg::hafc_kind_e i_req_kind,
  input wire logic i_req_in_host,
  input wire logic i_req_to_host,
  input wire logic [31:0] i_req_data,
  // Object result
  output logic o_rsp_valid,
  output logic [31:0] o_rsp_data,
  output logic [19:0] o_rsp_phys,
  output logic o_rsp_addr_err,
  // Reply field merge
  input wire logic [31:0] i_rep_req_field,
  input wire logic [31:0] i_rep_new_field,
  input wire logic [31:0] i_rep_pres_mask,
  output logic [31:0] o_rep_field
);

  typedef struct packed {
    hafc_pkg::hafc_state_e state;
    logic conv_en;
    logic abs_mode;
    logic [7:0] lw_sel;
    logic word_swap;
    logic bstr_swap;
    logic cfg_err;
    logic rsp_valid;
    logic [31:0] rsp_data;
    logic [19:0] rsp_phys;
    logic rsp_addr_err;
    logic [31:0] rep_field;
  } hafc_state_s;

  hafc_state_s st_r;
  hafc_state_s st_nxt;
  logic [31:0] conv_data;
  logic [31:0] native_lw;

  // Find which received byte carries the expected byte.
  function automatic logic [2:0] find_byte(input logic [31:0] raw, input logic [7:0] exp);
    find_byte = 3'h0;
    for (int j = hafc_pkg::LW_BYTES - 1; j >= 0; j--) begin
      if (raw[j*hafc_pkg::BYTE_W +: hafc_pkg::BYTE_W] == exp) begin
        find_byte = {1'b1, j[1:0]};
      end
    end
  endfunction : find_byte

  // Segment in bytes 2-3, offset in bytes 0-1.
  function automatic logic [19:0] seg_phys(input logic [31:0] a);
    seg_phys = {a[hafc_pkg::FIELD_W-1:hafc_pkg::SEG_LSB], hafc_pkg::SEG_PAD} +
      {hafc_pkg::SEG_PAD, a[hafc_pkg::SEG_LSB-1:0]};
  endfunction : seg_phys

  hafc_order_conv u_conv (
    .i_data(i_req_data),
    .i_kind(i_req_kind),
    .i_to_host(i_req_to_host),
    .i_enable(st_r.conv_en & i_req_in_host),
    .i_lw_sel(st_r.lw_sel),
    .i_word_swap(st_r.word_swap),
    .i_bstr_swap(st_r.bstr_swap),
    .o_data(conv_data)
  );

  // Address decode always looks at the native little-endian value.
  assign native_lw = i_req_to_host ? i_req_data : conv_data;

  always_comb begin
    logic [2:0] hit;
    logic all_hit;
    logic [7:0] sel;
    hit = 3'h0;
    all_hit = 1'b1;
    sel = hafc_pkg::LW_SEL_IDENT;
    st_nxt = st_r;
    st_nxt.rsp_valid = i_req_valid;
    case (st_r.state)
      hafc_pkg::ST_UNCONF: begin
        if (i_cfg_valid) begin
          // A later configuration is ignored so that settings cannot change mid-run.
          st_nxt.state = hafc_pkg::ST_CONF;
          st_nxt.conv_en = i_cfg_conv_en;
          st_nxt.abs_mode = i_cfg_abs_mode;
          st_nxt.cfg_err = 1'b0;
          if (i_cfg_conv_en) begin
            for (int i = 0; i < hafc_pkg::LW_BYTES; i++) begin
              hit = find_byte(i_cfg_lw_pat,
                hafc_pkg::LW_PATTERN[i*hafc_pkg::BYTE_W +: hafc_pkg::BYTE_W]);
              all_hit = all_hit & hit[2];
              sel[i*hafc_pkg::SEL_W +: hafc_pkg::SEL_W] = hit[1:0];
            end
            st_nxt.lw_sel = all_hit ? sel : hafc_pkg::LW_SEL_IDENT;
            st_nxt.word_swap = (i_cfg_word_pat != hafc_pkg::WORD_PATTERN);
            st_nxt.bstr_swap = (i_cfg_bstr_pat != hafc_pkg::BSTR_PATTERN);
            st_nxt.cfg_err = !all_hit ||
              ((i_cfg_word_pat != hafc_pkg::WORD_PATTERN) &&
               (i_cfg_word_pat != {hafc_pkg::WORD_PATTERN[7:0], hafc_pkg::WORD_PATTERN[15:8]})) ||
              ((i_cfg_bstr_pat != hafc_pkg::BSTR_PATTERN) &&
               (i_cfg_bstr_pat != {hafc_pkg::BSTR_PATTERN[7:0], hafc_pkg::BSTR_PATTERN[15:8]}));
          end
        end
      end
      hafc_pkg::ST_CONF: begin
        st_nxt.state = hafc_pkg::ST_CONF;
      end
      default: begin
        st_nxt.state = hafc_pkg::ST_UNCONF;
      end
    endcase
    if (i_req_valid) begin
      st_nxt.rsp_data = conv_data;
      st_nxt.rsp_phys = hafc_pkg::ZERO_PHYS;
      st_nxt.rsp_addr_err = 1'b0;
      case (i_req_kind)
        hafc_pkg::KIND_ADDR_LOCAL: begin
          st_nxt.rsp_phys = seg_phys(native_lw);
        end
        hafc_pkg::KIND_ADDR_HOST: begin
          if (st_r.abs_mode) begin
            st_nxt.rsp_phys = {hafc_pkg::ABS_PAD, native_lw[hafc_pkg::ABS_W-1:0]};
            // Reserved bits are the host's to keep clear; flagged, not trusted.
            st_nxt.rsp_addr_err =
              (native_lw[hafc_pkg::FIELD_W-1:hafc_pkg::ABS_W] != hafc_pkg::ABS_RSVD_ZERO);
          end else begin
            st_nxt.rsp_phys = seg_phys(native_lw);
          end
        end
        default: begin
          st_nxt.rsp_phys = hafc_pkg::ZERO_PHYS;
        end
      endcase
    end
    st_nxt.rep_field = (i_rep_req_field & i_rep_pres_mask) |
      (i_rep_new_field & ~i_rep_pres_mask);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_r <= '{state: hafc_pkg::ST_UNCONF, conv_en: 1'b0, abs_mode: 1'b0,
                lw_sel: hafc_pkg::LW_SEL_IDENT, word_swap: 1'b0, bstr_swap: 1'b0,
                cfg_err: 1'b0, rsp_valid: 1'b0, rsp_data: hafc_pkg::ZERO_LW,
                rsp_phys: hafc_pkg::ZERO_PHYS, rsp_addr_err: 1'b0,
                rep_field: hafc_pkg::ZERO_LW};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_cfg_done = (st_r.state == hafc_pkg::ST_CONF);
  assign o_cfg_err = st_r.cfg_err;
  assign o_rsp_valid = st_r.rsp_valid;
  assign o_rsp_data = st_r.rsp_data;
  assign o_rsp_phys = st_r.rsp_phys;
  assign o_rsp_addr_err = st_r.rsp_addr_err;
  assign o_rep_field = st_r.rep_field;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  a_rsp_latency: assert property (i_req_valid |=> o_rsp_valid)
    else $error("response did not follow request");
  a_local_seg: assert property ((i_req_valid && i_req_kind == hafc_pkg::KIND_ADDR_LOCAL &&
    !i_req_in_host && !i_req_to_host) |=>
    o_rsp_phys == {$past(i_req_data[31:16]), 4'h0} + {4'h0, $past(i_req_data[15:0])})
    else $error("local address not decoded segmented");
  a_abs_decode: assert property ((i_req_valid && i_req_kind == hafc_pkg::KIND_ADDR_HOST &&
    st_r.abs_mode && !i_req_in_host) |=>
    o_rsp_phys == {2'h0, $past(i_req_data[17:0])})
    else $error("absolute address decode wrong");
  a_abs_rsvd: assert property ((i_req_valid && i_req_kind == hafc_pkg::KIND_ADDR_HOST &&
    st_r.abs_mode && !i_req_in_host) |=>
    o_rsp_addr_err == ($past(i_req_data[31:18]) != 14'h0000))
    else $error("reserved bit flag wrong");
  a_no_conv: assert property ((i_req_valid && !st_r.conv_en) |=>
    o_rsp_data == $past(i_req_data))
    else $error("data changed with conversion off");
  a_local_native: assert property ((i_req_valid && !i_req_in_host) |=>
    o_rsp_data == $past(i_req_data))
    else $error("local object reordered");
  a_payload_bstr: assert property ((i_req_valid && i_req_kind == hafc_pkg::KIND_BSTR &&
    !st_r.bstr_swap) |=> o_rsp_data == $past(i_req_data))
    else $error("payload got a typed conversion");
  a_settings_hold: assert property ((st_r.state == hafc_pkg::ST_CONF) |=>
    $stable(st_r.conv_en) && $stable(st_r.abs_mode) && $stable(st_r.lw_sel) && o_cfg_done)
    else $error("settings changed after configuration");
  a_cfg_take: assert property ((!o_cfg_done && i_cfg_valid) |=>
    o_cfg_done && st_r.conv_en == $past(i_cfg_conv_en))
    else $error("configuration not captured");
  a_preserved: assert property (!i_reset |=> ((o_rep_field & $past(i_rep_pres_mask)) ==
    ($past(i_rep_req_field) & $past(i_rep_pres_mask))))
    else $error("preserved field not echoed");

  c_cfg_conv: cover property (!o_cfg_done && i_cfg_valid && i_cfg_conv_en ##1 !o_cfg_err);
  c_host_abs: cover property (i_req_valid && i_req_kind == hafc_pkg::KIND_ADDR_HOST &&
    st_r.abs_mode && st_r.conv_en && i_req_in_host);
  c_addr_err: cover property (o_rsp_valid && o_rsp_addr_err);
  c_word_swap: cover property (i_req_valid && i_req_kind == hafc_pkg::KIND_WORD && st_r.word_swap);

endmodule : hafc_top

// ---- rtl/hafc_pkg.sv ----
package hafc_pkg;

  // Kind of object carried by one request.
  typedef enum logic [2:0] {
    KIND_BSTR = 3'h0,
    KIND_WORD = 3'h1,
    KIND_LWORD = 3'h2,
    KIND_ADDR_LOCAL = 3'h3,
    KIND_ADDR_HOST = 3'h4
  } hafc_kind_e;

  typedef enum logic [0:0] {
    ST_UNCONF = 1'h0,
    ST_CONF = 1'h1
  } hafc_state_e;

  localparam int BYTE_W = 8;
  localparam int LW_BYTES = 4;
  localparam int SEL_W = 2;
  localparam int PHYS_W = 20;
  localparam int ABS_W = 18;
  localparam int SEG_SHIFT = 4;
  localparam int SEG_LSB = 16;
  localparam int FIELD_W = 32;

  // Known pattern as it must appear in native little-endian order.
  localparam logic [31:0] LW_PATTERN = 32'h0103070f;
  localparam logic [15:0] WORD_PATTERN = 16'h0102;
  localparam logic [15:0] BSTR_PATTERN = 16'h0201;

  localparam logic [7:0] LW_SEL_IDENT = 8'he4;
  localparam logic [31:0] ZERO_LW = 32'h00000000;
  localparam logic [19:0] ZERO_PHYS = 20'h00000;
  localparam logic [13:0] ABS_RSVD_ZERO = 14'h0000;
  localparam logic [1:0] ABS_PAD = 2'h0;
  localparam logic [3:0] SEG_PAD = 4'h0;

endpackage : hafc_pkg

// ---- rtl/hafc_order_conv.sv ----
`timescale 1ns/1ps
module hafc_order_conv (
  // Object in
  input wire logic [31:0] i_data,
  input wire hafc_pkg::hafc_kind_e i_kind,
  input wire logic i_to_host,
  input wire logic i_enable,
  // Derived conversion settings
  input wire logic [7:0] i_lw_sel,
  input wire logic i_word_swap,
  input wire logic i_bstr_swap,
  // Object out
  output logic [31:0] o_data
);

  function automatic logic [31:0] swap_pairs(input logic [31:0] d);
    swap_pairs = {d[23:16], d[31:24], d[7:0], d[15:8]};
  endfunction : swap_pairs

  always_comb begin
    logic [1:0] sel;
    sel = 2'h0;
    o_data = i_data;
    if (i_enable) begin
      case (i_kind)
        hafc_pkg::KIND_BSTR: begin
          // Payload gets only the byte-string conversion; its type is unknown here.
          if (i_bstr_swap) begin
            o_data = swap_pairs(i_data);
          end
        end
        hafc_pkg::KIND_WORD: begin
          if (i_word_swap) begin
            o_data = swap_pairs(i_data);
          end
        end
        hafc_pkg::KIND_LWORD, hafc_pkg::KIND_ADDR_LOCAL, hafc_pkg::KIND_ADDR_HOST: begin
          // Addresses travel through the longword permutation.
          for (int i = 0; i < hafc_pkg::LW_BYTES; i++) begin
            sel = i_lw_sel[i*hafc_pkg::SEL_W +: hafc_pkg::SEL_W];
            if (i_to_host) begin
              o_data[sel*hafc_pkg::BYTE_W +: hafc_pkg::BYTE_W] =
                i_data[i*hafc_pkg::BYTE_W +: hafc_pkg::BYTE_W];
            end else begin
              o_data[i*hafc_pkg::BYTE_W +: hafc_pkg::BYTE_W] =
                i_data[sel*hafc_pkg::BYTE_W +: hafc_pkg::BYTE_W];
            end
          end
        end
        default: begin
          o_data = i_data;
        end
      endcase
    end
  end

endmodule : hafc_order_conv

// ---- verif/hafc_host_model.sv ----
`timescale 1ns/1ps
// Host processor and memory: shows each native object in the order the host keeps it.
module hafc_host_model (
  // Host order
  input wire logic i_swap,
  // Object
  input wire logic [31:0] i_native,
  input wire hafc_pkg::hafc_kind_e i_kind,
  output logic [31:0] o_raw,
  // Known pattern, placed at an even address
  output logic [31:0] o_lw_pat,
  output logic [15:0] o_word_pat,
  output logic [15:0] o_bstr_pat
);
  function automatic logic [31:0] rev_bytes(input logic [31:0] d);
    rev_bytes = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction : rev_bytes

  // With conversion off the bench clears i_swap, so the host keeps native order.
  always_comb begin
    o_raw = i_native;
    if (i_swap && i_kind <= hafc_pkg::KIND_WORD) begin
      o_raw = {i_native[23:16], i_native[31:24], i_native[7:0], i_native[15:8]};
    end else if (i_swap) begin
      o_raw = rev_bytes(i_native);
    end
  end
  assign o_lw_pat = i_swap ? rev_bytes(hafc_pkg::LW_PATTERN) : hafc_pkg::LW_PATTERN;
  assign o_word_pat = i_swap ? {hafc_pkg::WORD_PATTERN[7:0], hafc_pkg::WORD_PATTERN[15:8]} :
    hafc_pkg::WORD_PATTERN;
  assign o_bstr_pat = i_swap ? {hafc_pkg::BSTR_PATTERN[7:0], hafc_pkg::BSTR_PATTERN[15:8]} :
    hafc_pkg::BSTR_PATTERN;
endmodule : hafc_host_model

// ---- verif/hafc_top_tb_top.sv ----
`timescale 1ns/1ps
module hafc_top_tb_top;
  logic i_sys_clk = 1'h0, i_reset = 1'h1, i_cfg_valid = 1'h0, i_cfg_conv_en = 1'h0;
  logic i_cfg_abs_mode = 1'h0, i_req_valid = 1'h0, i_req_in_host = 1'h0, i_req_to_host = 1'h0;
  logic [31:0] i_cfg_lw_pat = 32'h00000000, i_req_data = 32'h00000000;
  logic [15:0] i_cfg_word_pat = 16'h0000, i_cfg_bstr_pat = 16'h0000;
  logic [31:0] i_rep_req_field = 32'h00000000, i_rep_new_field = 32'h00000000;
  logic [31:0] i_rep_pres_mask = 32'h00000000, i_native = 32'h00000000;
  hafc_pkg::hafc_kind_e i_req_kind = hafc_pkg::KIND_BSTR, i_kind = hafc_pkg::KIND_BSTR;
  logic i_swap = 1'h0, o_cfg_done, o_cfg_err, o_rsp_valid, o_rsp_addr_err;
  logic [31:0] o_rsp_data, o_rep_field, o_raw, o_lw_pat, ed, er, a, b, c;
  logic [19:0] o_rsp_phys, ep;
  logic [15:0] o_word_pat, o_bstr_pat;
  logic [3:0] md;
  logic ee, ev, ih, th;
  int n_mismatch = 0, checked = 0, cycles = 0;
  hafc_top hafc_top_inst (.i_sys_clk, .i_reset, .i_cfg_valid, .i_cfg_conv_en, .i_cfg_abs_mode,
    .i_cfg_lw_pat, .i_cfg_word_pat, .i_cfg_bstr_pat, .o_cfg_done, .o_cfg_err, .i_req_valid,
    .i_req_kind, .i_req_in_host, .i_req_to_host, .i_req_data, .o_rsp_valid, .o_rsp_data,
    .o_rsp_phys, .o_rsp_addr_err, .i_rep_req_field, .i_rep_new_field, .i_rep_pres_mask,
    .o_rep_field);
  hafc_host_model hafc_host_model_inst (.i_swap, .i_native, .i_kind, .o_raw, .o_lw_pat,
    .o_word_pat, .o_bstr_pat);
  always #10 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task finish_test;
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [19:0] phys(input logic [31:0] v, input hafc_pkg::hafc_kind_e k);
    if (k == hafc_pkg::KIND_ADDR_HOST && md[2]) return {2'h0, v[17:0]};
    if (k >= hafc_pkg::KIND_ADDR_LOCAL) return {v[31:16], 4'h0} + {4'h0, v[15:0]};
    return 20'h00000;
  endfunction : phys
  // Mode bits: conversion, absolute, host swaps, broken pattern.
  task start(input logic [3:0] m);
    md = m;
    i_swap = m[1];
    @(posedge i_sys_clk);
    i_reset <= 1'h1;
    repeat (10) @(posedge i_sys_clk);
    i_reset <= 1'h0;
    i_cfg_valid <= 1'h1;
    i_cfg_conv_en <= m[3];
    i_cfg_abs_mode <= m[2];
    i_cfg_lw_pat <= m[0] ? 32'h00000000 : o_lw_pat;
    i_cfg_word_pat <= o_word_pat;
    i_cfg_bstr_pat <= o_bstr_pat;
    #1;
    chk(o_cfg_done, 1'h0);
    chk(o_rsp_valid, 1'h0);
    chk(o_rep_field, 32'h00000000);
    @(posedge i_sys_clk);
    i_cfg_conv_en <= ~m[3];
    i_cfg_abs_mode <= ~m[2];
    #1;
    chk(o_cfg_done, 1'h1);
    chk(o_cfg_err, m[0]);
    @(posedge i_sys_clk);
    i_cfg_valid <= 1'h0;
    #1;
    chk(o_cfg_done, 1'h1);
  endtask : start
  task pick(input int i);
    i_kind = hafc_pkg::hafc_kind_e'(i < 3 ? 3 + (i > 0) : $urandom_range(4, 0));
    ih = 1'($urandom_range(1, 0));
    th = 1'($urandom_range(1, 0));
    i_native = i == 0 ? 32'hffffffff : i == 1 ? 32'h0003ffff : i == 2 ? 32'h00040000 : $urandom();
    // Most absolute addresses are legal; the first five and every fourth after them keep their upper bits to exercise the error flag.
    if (i > 4 && i % 4 != 0 && i_kind == hafc_pkg::KIND_ADDR_HOST && md[2]) begin
      i_native[31:18] = 14'h0000;
    end
    i_swap = md[1] & ih;
  endtask : pick
  task run;
    pick(0);
    for (int i = 1; i <= 42; i++) begin
      @(posedge i_sys_clk);
      a = $urandom();
      b = $urandom();
      c = $urandom();
      i_req_valid <= i <= 40;
      i_req_kind <= i_kind;
      i_req_in_host <= ih;
      i_req_to_host <= th;
      i_req_data <= th ? i_native : o_raw;
      i_rep_req_field <= a;
      i_rep_new_field <= b;
      i_rep_pres_mask <= c;
      #1;
      if (i > 1) begin
        chk(o_rsp_valid, ev);
        if (ev) begin
          chk(o_rsp_data, ed);
          chk(o_rsp_phys, ep);
          chk(o_rsp_addr_err, ee);
        end
        chk(o_rep_field, er);
      end
      ev = i <= 40;
      ed = th ? o_raw : i_native;
      ep = phys(i_native, i_kind);
      ee = i_kind == hafc_pkg::KIND_ADDR_HOST && md[2] && i_native[31:18] != 14'h0000;
      er = (a & c) | (b & ~c);
      pick(i);
    end
  endtask : run
  initial begin
    void'($urandom(37));
    for (int m = 0; m < 4; m++) begin
      start(m == 0 ? 4'h0 : m == 1 ? 4'he : m == 2 ? 4'h8 : 4'hd);
      run();
    end
    finish_test();
  end
endmodule : hafc_top_tb_top
